// ==== core/ims_sequencer.sv ====
// idle mode, sleep and wake sequencer with wishbone register access

module ims_sequencer #(
	parameter int IRQ_N       = 8,
	parameter int STAB_CYCLES = ims_pkg::STAB_CYCLES,
	parameter int WDT_CYCLES  = ims_pkg::WDT_CYCLES
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// cpu core events
	input  wire logic             sleep_instr,
	input  wire logic             watchdog_clear_instr,
	input  wire logic [IRQ_N-1:0] irq_flag,
	input  wire logic [IRQ_N-1:0] irq_enable,
	// configuration fuses
	input  wire logic [1:0]       primary_osc_type,
	input  wire logic             fast_startup_en,
	input  wire logic             fail_monitor_en,
	input  wire logic             watchdog_en,
	// oscillator pins
	input  wire logic             primary_ready,
	input  wire logic             secondary_started,
	input  wire logic             clock_lost,
	// clock control
	output logic                  cpu_clk_en,
	output logic                  periph_clk_en,
	output logic      [1:0]       clk_sel,
	output logic                  primary_osc_en,
	output logic                  secondary_osc_en,
	output logic                  fast_osc_en,
	output logic                  slow_osc_en,
	// cpu control
	output logic                  irq_vector,
	output logic                  watchdog_reset
);

	localparam int CSD_W  = $clog2(ims_pkg::CSD_CYCLES + 1);
	localparam int STAB_W = $clog2(STAB_CYCLES + 1);
	localparam int WDT_W  = $clog2(WDT_CYCLES + 1);

	// clock source chosen by the select field
	function automatic logic [1:0] sel_of(input logic [1:0] css);
		sel_of = css[1] ? ims_pkg::SEL_INT : css;
	endfunction : sel_of

	ims_pkg::ims_state_t state_ff, nxt_state;
	logic [8:0]        ctrl_ff;
	logic [1:0]        sel_ff, nxt_sel;
	logic [CSD_W-1:0]  csd_cnt_ff;
	logic [STAB_W-1:0] stab_cnt_ff;
	logic [WDT_W-1:0]  wdt_cnt_ff;
	logic              psd_ff, nxt_psd;
	logic              secondary_run_ff, nxt_secondary_run;
	logic              stable_ff;
	logic              pend_ff, nxt_pend;
	logic              need_ost_ff;
	logic              from_idle_ff;
	logic              by_irq_ff;
	logic              cpu_ff, per_ff, pri_en_ff, fast_ff, slow_ff;
	logic              vec_ff, wrst_ff, ack_ff;
	logic [31:0]       dat_ff;
	logic              pri_s1, pri_s2, sec_s1, sec_s2;
	logic              lost_s1, lost_s2, lost_s3;

	// two-flop synchronisers for oscillator pins, with a third flop on clock_lost for its edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{pri_s1, pri_s2, sec_s1, sec_s2} <= 4'h0;
			{lost_s1, lost_s2, lost_s3} <= 3'h0;
		end else begin
			{pri_s1, pri_s2} <= {primary_ready, pri_s1};
			{sec_s1, sec_s2} <= {secondary_started, sec_s1};
			{lost_s1, lost_s2, lost_s3} <= {clock_lost, lost_s1, lost_s2};
		end
	end

	// control field views
	wire       idle_select     = ctrl_ff[ims_pkg::CTRL_IDLE];
	wire [1:0] clock_src_sel   = ctrl_ff[ims_pkg::CTRL_CSS +: 2];
	wire [2:0] int_freq_sel    = ctrl_ff[ims_pkg::CTRL_IFS +: 3];
	wire       int_source_sel  = ctrl_ff[ims_pkg::CTRL_ISRC];
	wire       sec_osc_enable  = ctrl_ff[ims_pkg::CTRL_SECEN];
	wire       global_irq_en   = ctrl_ff[ims_pkg::CTRL_GIE];
	wire [1:0] want_sel        = sel_of(clock_src_sel);

	// bus decode
	wire wb_req   = wb_cyc_i & wb_stb_i & ~ack_ff;
	wire hit_ctrl = wb_adr_i[7:2] == ims_pkg::REG_CTRL[7:2];
	wire hit_stat = wb_adr_i[7:2] == ims_pkg::REG_STAT[7:2];
	wire wr_ctrl  = wb_req & wb_we_i & hit_ctrl;
	wire [8:0] wr_mask = {wb_sel_i[1], {8{wb_sel_i[0]}}};
	wire [8:0] ctrl_wr = (ctrl_ff & ~wr_mask) | (wb_dat_i[8:0] & wr_mask);

	// status word
	wire [31:0] stat_word = {23'h0, per_ff, cpu_ff, state_ff, 1'b0,
		stable_ff, secondary_run_ff, psd_ff};
	wire [31:0] rd_data = hit_ctrl ? {23'h0, ctrl_ff} :
		hit_stat ? stat_word : 32'h0;

	// event decode
	wire sleeping  = state_ff == ims_pkg::ST_IDLE | state_ff == ims_pkg::ST_SLEEP;
	wire irq_hit   = |(irq_flag & irq_enable);
	wire wdt_to    = watchdog_en & (wdt_cnt_ff == WDT_W'(WDT_CYCLES - 1));
	wire wake_evt  = sleeping & (irq_hit | wdt_to);
	// wake from idle: the flag is only loaded at the wake edge, so use the state there
	wire idle_wake = state_ff == ims_pkg::ST_WAKE ? from_idle_ff :
		state_ff == ims_pkg::ST_IDLE;
	wire ost_skip  = primary_osc_type == ims_pkg::OSC_EXT |
		primary_osc_type == ims_pkg::OSC_INTERNAL;
	wire two_speed = fast_startup_en | fail_monitor_en;
	wire sec_block = idle_select & want_sel == ims_pkg::SEL_SEC & ~sec_osc_enable;
	wire go_sleep  = state_ff == ims_pkg::ST_RUN & sleep_instr & ~sec_block;
	wire fast_req  = (int_freq_sel != 3'h0) | int_source_sel;
	wire fast_on   = fast_req & nxt_state != ims_pkg::ST_SLEEP;
	wire stab_done = stab_cnt_ff == STAB_W'(STAB_CYCLES - 1);
	wire ost_exit  = state_ff == ims_pkg::ST_OST & nxt_state == ims_pkg::ST_RUN;
	wire wake_done = state_ff == ims_pkg::ST_WAKE & nxt_state == ims_pkg::ST_RUN;
	wire ifs_chg   = wr_ctrl & wb_sel_i[0] &
		wb_dat_i[ims_pkg::CTRL_IFS +: 3] != int_freq_sel &
		sel_ff == ims_pkg::SEL_INT & state_ff != ims_pkg::ST_SLEEP;
	wire wdt_clr   = sleep_instr | watchdog_clear_instr |
		(fail_monitor_en & lost_s2 & ~lost_s3) | ifs_chg | wdt_to;

	// next state of the sequencer
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ims_pkg::ST_OST: begin
				if (pri_s2 | ost_skip | two_speed)
					nxt_state = ims_pkg::ST_RUN;
			end
			ims_pkg::ST_RUN: begin
				if (go_sleep)
					nxt_state = idle_select ? ims_pkg::ST_IDLE : ims_pkg::ST_SLEEP;
			end
			ims_pkg::ST_IDLE, ims_pkg::ST_SLEEP: begin
				if (wake_evt)
					nxt_state = ims_pkg::ST_WAKE;
			end
			ims_pkg::ST_WAKE: begin
				if (csd_cnt_ff == CSD_W'(0) & (~need_ost_ff | pri_s2))
					nxt_state = ims_pkg::ST_RUN;
			end
			default: nxt_state = ims_pkg::ST_OST;
		endcase
	end

	// clock source and status bits
	always_comb begin
		nxt_sel     = sel_ff;
		nxt_psd     = psd_ff;
		nxt_secondary_run = secondary_run_ff;
		nxt_pend    = pend_ff;
		if (ost_exit) begin
			nxt_pend = two_speed & ~pri_s2 & ~ost_skip;
			nxt_sel  = nxt_pend ? ims_pkg::SEL_INT : ims_pkg::SEL_PRI;
			nxt_psd  = ~nxt_pend & primary_osc_type != ims_pkg::OSC_INTERNAL;
		end else if (state_ff == ims_pkg::ST_RUN & pend_ff & pri_s2) begin
			nxt_pend = 1'b0;
			nxt_sel  = ims_pkg::SEL_PRI;
			nxt_psd  = 1'b1;
		end
		if (go_sleep & idle_select) begin
			nxt_sel  = want_sel;
			nxt_pend = 1'b0;
			if (want_sel != ims_pkg::SEL_PRI)
				nxt_psd = 1'b0;
			nxt_secondary_run = want_sel == ims_pkg::SEL_SEC;
		end else if (go_sleep) begin
			nxt_pend    = 1'b0;
			nxt_psd     = 1'b0;
			nxt_secondary_run = 1'b0;
		end
		if (state_ff == ims_pkg::ST_SLEEP & wake_evt) begin
			nxt_sel = want_sel;
		end
		if (wake_done & ~from_idle_ff) begin
			nxt_psd     = sel_ff == ims_pkg::SEL_PRI;
			nxt_secondary_run = sel_ff == ims_pkg::SEL_SEC;
		end
	end

	// bus slave registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff  <= 1'b0;
			dat_ff  <= 32'h0;
			ctrl_ff <= ims_pkg::CTRL_RESET;
		end else begin
			ack_ff <= wb_req;
			if (wb_req)
				dat_ff <= wb_we_i ? 32'h0 : rd_data;
			if (wr_ctrl)
				ctrl_ff <= ctrl_wr;
		end
	end

	// sequencer state and status
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff   <= ims_pkg::ST_OST;
			sel_ff     <= ims_pkg::SEL_PRI;
			psd_ff     <= 1'b0;
			secondary_run_ff <= 1'b0;
			pend_ff    <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			sel_ff     <= nxt_sel;
			psd_ff     <= nxt_psd;
			secondary_run_ff <= nxt_secondary_run;
			pend_ff    <= nxt_pend;
		end
	end

	// wake bookkeeping and cpu ready delay
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			csd_cnt_ff   <= CSD_W'(0);
			need_ost_ff  <= 1'b0;
			from_idle_ff <= 1'b0;
			by_irq_ff    <= 1'b0;
		end else if (wake_evt) begin
			csd_cnt_ff   <= CSD_W'(ims_pkg::CSD_CYCLES - 1);
			from_idle_ff <= state_ff == ims_pkg::ST_IDLE;
			by_irq_ff    <= irq_hit;
			need_ost_ff  <= state_ff == ims_pkg::ST_SLEEP & ~ost_skip &
				want_sel == ims_pkg::SEL_PRI;
		end else if (csd_cnt_ff != CSD_W'(0)) begin
			csd_cnt_ff <= csd_cnt_ff - CSD_W'(1);
		end
	end

	// fast internal output stabilisation
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			stab_cnt_ff <= STAB_W'(0);
			stable_ff   <= 1'b0;
		end else if (!fast_on) begin
			stab_cnt_ff <= STAB_W'(0);
			stable_ff   <= ost_exit & primary_osc_type == ims_pkg::OSC_INTERNAL;
		end else begin
			if (!stab_done)
				stab_cnt_ff <= stab_cnt_ff + STAB_W'(1);
			stable_ff <= stable_ff | stab_done |
				(ost_exit & primary_osc_type == ims_pkg::OSC_INTERNAL);
		end
	end

	// watchdog counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wdt_cnt_ff <= WDT_W'(0);
		else if (wdt_clr | ~watchdog_en)
			wdt_cnt_ff <= WDT_W'(0);
		else
			wdt_cnt_ff <= wdt_cnt_ff + WDT_W'(1);
	end

	// clock gating and oscillator enables
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cpu_ff    <= 1'b0;
			per_ff    <= 1'b0;
			pri_en_ff <= 1'b1;
			fast_ff   <= 1'b0;
			slow_ff   <= 1'b0;
		end else begin
			cpu_ff    <= nxt_state == ims_pkg::ST_RUN;
			per_ff    <= nxt_state == ims_pkg::ST_RUN |
				((nxt_state == ims_pkg::ST_IDLE |
				(nxt_state == ims_pkg::ST_WAKE & idle_wake)) &
				~(nxt_sel == ims_pkg::SEL_SEC & ~sec_s2));
			pri_en_ff <= nxt_state == ims_pkg::ST_OST | nxt_pend |
				(nxt_sel == ims_pkg::SEL_PRI & nxt_state != ims_pkg::ST_SLEEP);
			fast_ff   <= fast_on;
			slow_ff   <= watchdog_en | fail_monitor_en |
				(nxt_sel == ims_pkg::SEL_INT & nxt_state != ims_pkg::ST_SLEEP);
		end
	end

	// cpu control pulses
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vec_ff  <= 1'b0;
			wrst_ff <= 1'b0;
		end else begin
			vec_ff  <= wake_done & by_irq_ff & global_irq_en;
			wrst_ff <= wdt_to & state_ff == ims_pkg::ST_RUN;
		end
	end

	// output ports
	assign wb_ack_o         = ack_ff;
	assign wb_dat_o         = dat_ff;
	assign cpu_clk_en       = cpu_ff;
	assign periph_clk_en    = per_ff;
	assign clk_sel          = sel_ff;
	assign primary_osc_en   = pri_en_ff;
	assign secondary_osc_en = ctrl_ff[ims_pkg::CTRL_SECEN];
	assign fast_osc_en      = fast_ff;
	assign slow_osc_en      = slow_ff;
	assign irq_vector       = vec_ff;
	assign watchdog_reset   = wrst_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_primary_idle;
		state_ff == ims_pkg::ST_IDLE && sel_ff == ims_pkg::SEL_PRI
			|-> !cpu_ff && primary_osc_en && psd_ff;
	endproperty
	a_primary_idle: assert property (p_primary_idle) else $error("primary idle clocking wrong");

	property p_sec_block;
		state_ff == ims_pkg::ST_RUN && sleep_instr && sec_block |=> state_ff == ims_pkg::ST_RUN;
	endproperty
	a_sec_block: assert property (p_sec_block) else $error("blocked sleep was taken");

	property p_sec_wait;
		state_ff == ims_pkg::ST_IDLE && sel_ff == ims_pkg::SEL_SEC && !$past(sec_s2)
			|-> !per_ff;
	endproperty
	a_sec_wait: assert property (p_sec_wait) else $error("clocks before secondary start");

	property p_wake_per;
		state_ff == ims_pkg::ST_IDLE && wake_evt && per_ff &&
			(sel_ff != ims_pkg::SEL_SEC || sec_s2) |=> per_ff;
	endproperty
	a_wake_per: assert property (p_wake_per) else $error("peripherals stop on wake");

	property p_fast_off;
		!fast_req |=> !fast_osc_en && !stable_ff;
	endproperty
	a_fast_off: assert property (p_fast_off) else $error("fast output on while off");

	property p_csd_load;
		state_ff != ims_pkg::ST_WAKE ##1 state_ff == ims_pkg::ST_WAKE
			|-> csd_cnt_ff == CSD_W'(ims_pkg::CSD_CYCLES - 1) && !cpu_ff;
	endproperty
	a_csd_load: assert property (p_csd_load) else $error("ready delay not loaded");

	property p_no_wake;
		sleeping && !irq_hit && !wdt_to |=> state_ff == $past(state_ff);
	endproperty
	a_no_wake: assert property (p_no_wake) else $error("left low power without cause");

	property p_wdt_reset;
		state_ff == ims_pkg::ST_RUN && wdt_to |=> watchdog_reset ##1 !watchdog_reset;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");

	property p_vector;
		$rose(irq_vector) |-> $past(global_irq_en) && cpu_ff;
	endproperty
	a_vector: assert property (p_vector) else $error("vector without global enable");

	property p_full_sleep;
		go_sleep && !idle_select |=> state_ff == ims_pkg::ST_SLEEP && !psd_ff
			&& !secondary_run_ff ##1 !cpu_ff && !per_ff;
	endproperty
	a_full_sleep: assert property (p_full_sleep) else $error("sleep status not cleared");

	property p_wdt_clear;
		watchdog_clear_instr |=> wdt_cnt_ff == WDT_W'(0);
	endproperty
	a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared");

endmodule : ims_sequencer

// ==== shared/ims_pkg.sv ====
// constants and types of the idle mode and wake sequencer
package ims_pkg;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;

	// control register fields
	localparam int CTRL_IDLE = 0;
	localparam int CTRL_CSS  = 1;
	localparam int CTRL_IFS  = 3;
	localparam int CTRL_ISRC = 6;
	localparam int CTRL_SECEN = 7;
	localparam int CTRL_GIE  = 8;
	localparam int CTRL_W    = 9;
	localparam logic [8:0] CTRL_RESET = 9'h000;

	// status register fields
	localparam int STAT_PSD  = 0;
	localparam int STAT_SEC  = 1;
	localparam int STAT_IFS  = 2;
	localparam int STAT_MODE = 4;
	localparam int STAT_CPU  = 7;
	localparam int STAT_PER  = 8;

	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int CSD_TIME_NS   = 2000;
	localparam int STAB_TIME_NS  = 1000000;
	localparam int WDT_TIME_NS   = 4000000;
	localparam int CSD_CYCLES  = (CSD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDT_CYCLES  = WDT_TIME_NS / CLK_PERIOD_NS;

	// clock source selection
	localparam logic [1:0] SEL_PRI = 2'h0;
	localparam logic [1:0] SEL_SEC = 2'h1;
	localparam logic [1:0] SEL_INT = 2'h2;

	// primary oscillator types
	localparam logic [1:0] OSC_CRYSTAL  = 2'h0;
	localparam logic [1:0] OSC_XTAL_PLL = 2'h1;
	localparam logic [1:0] OSC_EXT      = 2'h2;
	localparam logic [1:0] OSC_INTERNAL = 2'h3;

	// sequencer states
	typedef enum logic [2:0] {
		ST_OST   = 3'b000,
		ST_RUN   = 3'b001,
		ST_IDLE  = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE  = 3'b100
	} ims_state_t;

endpackage : ims_pkg

// ==== test/idle_mode_and_wake_sequencer_tb_top.sv ====
// self-checking bench of the idle mode and wake sequencer
module idle_mode_and_wake_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int STAB = 20;
	localparam int WDT  = 64;

	logic        clk    = 1'b0;
	logic        rstn   = 1'b0;
	logic        cyc    = 1'b0;
	logic        stb    = 1'b0;
	logic        we     = 1'b0;
	logic [7:0]  adr    = 8'h00;
	logic [31:0] dat    = 32'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        slp    = 1'b0;
	logic        wdc    = 1'b0;
	logic [7:0]  irq_f  = 8'h00;
	logic [7:0]  irq_e  = 8'h00;
	logic        wd_en  = 1'b0;
	logic        fsu    = 1'b0;
	logic        pri_rdy;
	logic        sec_st;
	logic        cpu_en;
	logic        per_en;
	logic [1:0]  csel;
	logic        pri_en;
	logic        sec_en;
	logic        fast_en;
	logic        slow_en;
	logic        vec;
	logic        wdr;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          errors = 0;
	int          checked = 0;
	int          cycles = 0;
	int          wdr_cnt = 0;

	// clock at 100 ns period
	always #50 clk = ~clk;

	ims_sequencer #(.IRQ_N(8), .STAB_CYCLES(STAB), .WDT_CYCLES(WDT)) dut (
		.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sleep_instr(slp), .watchdog_clear_instr(wdc), .irq_flag(irq_f), .irq_enable(irq_e),
		.primary_osc_type(ims_pkg::OSC_CRYSTAL), .fast_startup_en(fsu),
		.fail_monitor_en(1'b0), .watchdog_en(wd_en), .primary_ready(pri_rdy),
		.secondary_started(sec_st), .clock_lost(1'b0), .cpu_clk_en(cpu_en),
		.periph_clk_en(per_en), .clk_sel(csel), .primary_osc_en(pri_en),
		.secondary_osc_en(sec_en), .fast_osc_en(fast_en), .slow_osc_en(slow_en),
		.irq_vector(vec), .watchdog_reset(wdr));

	ims_osc_model osc (
		.clk(clk), .rstn(rstn), .primary_osc_en(pri_en), .secondary_osc_en(sec_en),
		.primary_ready(pri_rdy), .secondary_started(sec_st));

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// one classic cycle: hold everything until ack is sampled high
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		// ack is sampled at the rising edge, and the request is released at that same edge
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	// a read notes its expected masked word before the request goes out
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		wb(1'b0, a, 32'h0);
	endtask : rd

	task pulse_sleep;
		@(posedge clk) slp <= 1'b1;
		@(posedge clk) slp <= 1'b0;
	endtask : pulse_sleep

	// counts falling edges until the cpu clock is back
	task wait_cpu(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cpu_en !== 1'b1 && n < 3000);
	endtask : wait_cpu

	// read data is compared against the oldest note at the acknowledging edge
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
			check(rdat & msk_q.pop_front(), exp_q.pop_front());
	end

	// watchdog reset pulses and the hang limit
	always @(posedge clk) begin
		cycles++;
		if (wdr === 1'b1)
			wdr_cnt++;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end

	initial begin
		int n;
		int b;
		logic [2:0] ifs;
		logic [31:0] ctl;
		logic [31:0] prev;
		b = $urandom(45);
		prev = 32'h0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		wait_cpu(n);
		rd(ims_pkg::REG_CTRL, 32'h0, 32'h1ff);
		check(32'(fast_en), 32'h0);
		rd(ims_pkg::REG_STAT, 32'h11, 32'h75);
		rd(8'h10, 32'h0, 32'hffffffff);
		// primary, secondary and internal idle in turn
		for (int m = 0; m < 3; m++) begin
			ifs = 3'($urandom_range(7, 1));
			b = $urandom_range(7, 0);
			ctl = {23'h0, m != 1, m == 1, 1'b0, m == 2 ? ifs : 3'h0, 2'(m), 1'b1};
			wb(1'b1, ims_pkg::REG_CTRL, (ctl & ~32'h86) | (prev & 32'h86));
			wb(1'b1, ims_pkg::REG_CTRL, ctl);
			pulse_sleep();
			repeat (3) @(negedge clk);
			check(32'(cpu_en), 32'h0);
			check(32'(per_en), 32'(m != 1));
			check(32'(pri_en), 32'(m == 0));
			check(32'(csel), 32'(m));
			if (m == 2)
				check(32'(fast_en), 32'h1);
			repeat (STAB + 30) @(negedge clk);
			check(32'(per_en), 32'h1);
			rd(ims_pkg::REG_STAT, 32'(m == 0) | 32'(m == 1) << 1 | 32'(m == 2) << 2, 32'h7);
			@(posedge clk) irq_f <= 8'(1 << b);
			repeat (30) @(negedge clk);
			check(32'(cpu_en), 32'h0);
			@(posedge clk) irq_f <= 8'h00;
			@(posedge clk) irq_e <= 8'(1 << b);
			@(posedge clk) irq_f <= 8'(1 << b);
			wait_cpu(n);
			check(32'(n), 32'(ims_pkg::CSD_CYCLES + 2));
			check(32'(vec), 32'(m != 1));
			check(32'(csel), 32'(m));
			check(32'(sec_en), 32'(m == 1));
			@(posedge clk) irq_f <= 8'h00;
			irq_e <= 8'h00;
			rd(ims_pkg::REG_CTRL, ctl, 32'h1ff);
			prev = ctl;
		end
		// secondary idle asked for with its oscillator disabled
		wb(1'b1, ims_pkg::REG_CTRL, 32'h3);
		pulse_sleep();
		repeat (3) @(negedge clk);
		check(32'(cpu_en), 32'h1);
		rd(ims_pkg::REG_STAT, 32'h10, 32'h70);
		// full sleep, then a watchdog wake into primary run
		wb(1'b1, ims_pkg::REG_CTRL, 32'h0);
		repeat (40) @(posedge clk);
		wd_en <= 1'b1;
		pulse_sleep();
		repeat (3) @(negedge clk);
		check(32'(pri_en), 32'h0);
		check(32'(per_en), 32'h0);
		check(32'(slow_en), 32'h1);
		rd(ims_pkg::REG_STAT, 32'h0, 32'h7);
		wait_cpu(n);
		check(32'(n >= WDT - 10 && n <= WDT + 60), 32'h1);
		check(32'(wdr_cnt), 32'h0);
		check(32'(csel), 32'(ims_pkg::SEL_PRI));
		rd(ims_pkg::REG_STAT, 32'h1, 32'h1);
		// clear instructions keep the watchdog from firing in run
		repeat (3) begin
			repeat (20) @(posedge clk);
			@(posedge clk) wdc <= 1'b1;
			@(posedge clk) wdc <= 1'b0;
		end
		check(32'(wdr_cnt), 32'h0);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (wdr_cnt == 0 && n < 300);
		check(32'(n >= WDT - 5 && n <= WDT + 5), 32'h1);
		// second reset with two-speed start-up: internal source until primary is ready
		@(posedge clk) rstn <= 1'b0;
		fsu   <= 1'b1;
		wd_en <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		wait_cpu(n);
		check(32'(n <= 3), 32'h1);
		check(32'(csel), 32'(ims_pkg::SEL_INT));
		check(32'(pri_en), 32'h1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (csel !== ims_pkg::SEL_PRI && n < 300);
		check(32'(n >= 10 && n <= 20), 32'h1);
		rd(ims_pkg::REG_STAT, 32'h11, 32'h77);
		// let the read compare finish before the verdict
		@(negedge clk);
		report_and_stop();
	end
endmodule : idle_mode_and_wake_sequencer_tb_top

// ==== test/ims_osc_model.sv ====
// oscillator start-up model standing at the far side of the sequencer
module ims_osc_model #(
	parameter int PRI_DLY = 12,
	parameter int SEC_DLY = 30
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// oscillator enables
	input  wire logic primary_osc_en,
	input  wire logic secondary_osc_en,
	// oscillator status
	output logic      primary_ready,
	output logic      secondary_started
);
	timeunit 1ns;
	timeprecision 1ns;

	int pri_cnt_ff;
	int sec_cnt_ff;

	// each oscillator needs a warm-up run after its enable, and stops at once without it
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pri_cnt_ff <= 0;
			sec_cnt_ff <= 0;
		end else begin
			pri_cnt_ff <= !primary_osc_en ? 0 : (pri_cnt_ff < PRI_DLY ? pri_cnt_ff + 1 : pri_cnt_ff);
			sec_cnt_ff <= !secondary_osc_en ? 0 : (sec_cnt_ff < SEC_DLY ? sec_cnt_ff + 1 : sec_cnt_ff);
		end
	end

	// ready flags follow the warm-up counts
	assign primary_ready     = pri_cnt_ff >= PRI_DLY;
	assign secondary_started = sec_cnt_ff >= SEC_DLY;
endmodule : ims_osc_model
